// ---- src/uie_consts.svh ----
// offsets, field positions, reset values and timing counts of the irq logic
`ifndef UIE_CONSTS_SVH
`define UIE_CONSTS_SVH

`define UIE_STATUS_OFS      16'h0310
`define UIE_GATE_OFS        16'h0314

`define UIE_BIT_ISO         9
`define UIE_BIT_ASYNC       8
`define UIE_BIT_PERIODIC    7
`define UIE_BIT_CLOCK       6
`define UIE_BIT_SUSPEND     5
`define UIE_BIT_DMA         3
`define UIE_BIT_FRAME       1

`define UIE_GATE_RESET      32'h0000_0000
`define UIE_STATUS_RESET    32'h0000_0000
`define UIE_SOURCE_MASK     32'h0000_03EA
`define UIE_SETTLE_MASK     32'h0000_0005

// settling time of the reserved bits after reset
`define UIE_SETTLE_NS       1000
`define UIE_CLK_NS          100

`endif

// ---- src/uie_pkg.sv ----
// types of the usb host irq enable logic
`default_nettype none
package uie_pkg;

    typedef struct packed {
        logic        iso_done;      // isochronous descriptor completion
        logic        async_done;    // asynchronous list completion
        logic        periodic_done; // periodic list completion
        logic        clock_stable;  // internal clocks became stable
        logic        suspend_entry; // controller entered suspend
        logic        dma_end;       // dma transfer ended
        logic        frame_start;   // start of frame
    } uie_events_t;

    typedef struct packed {
        logic        wr;            // write strobe
        logic        rd;            // read strobe
        logic [15:0] addr;          // byte address
        logic [31:0] wdata;         // write data
    } uie_req_t;

    typedef enum logic [0:0] {
        UIE_SETTLING,
        UIE_SETTLED
    } uie_settle_t;

endpackage
`default_nettype wire

// ---- src/uie_irq_logic.sv ----
// status flags, enable gate and irq line of the usb host controller
`timescale 1ns/10ps
`default_nettype none
`include "uie_consts.svh"

module uie_irq_logic #(
    parameter int SETTLE_CYCLES =
        (`UIE_SETTLE_NS + `UIE_CLK_NS - 1) / `UIE_CLK_NS
)(
    input  wire logic               mclk,     // system clock, 10 MHz
    input  wire logic               rst_n,    // synchronous reset, low
    input  wire uie_pkg::uie_req_t  req,      // register access request
    input  wire uie_pkg::uie_events_t events, // one-cycle event pulses
    output logic [31:0]             rdata,    // read data, next cycle
    output logic                    irq       // interrupt request, high
);

    // ********************************************************
    // settling of the reserved status bits
    // ********************************************************
    // reads before settling show status bits 2 and 0 low
    uie_pkg::uie_settle_t settle_q, settle_d;
    logic [15:0]          cnt_q, cnt_d;

    always_comb
    begin
        settle_d = settle_q;
        cnt_d    = cnt_q;
        case (settle_q)
            uie_pkg::UIE_SETTLING:
            begin
                if (cnt_q >= 16'(SETTLE_CYCLES - 1))
                    settle_d = uie_pkg::UIE_SETTLED;
                else
                    cnt_d = cnt_q + 16'h0001;
            end
            uie_pkg::UIE_SETTLED:
                cnt_d = cnt_q;
            default:
                settle_d = uie_pkg::UIE_SETTLING;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            settle_q <= uie_pkg::UIE_SETTLING;
            cnt_q    <= 16'h0000;
        end
        else
        begin
            settle_q <= settle_d;
            cnt_q    <= cnt_d;
        end
    end

    // ********************************************************
    // enable gate and sticky status flags
    // ********************************************************
    logic [31:0] gate_q, gate_d;
    logic [31:0] flag_q, flag_d;
    logic [31:0] evt;
    logic [31:0] status_view;
    logic        hit_status, hit_gate;

    assign hit_status = (req.addr == `UIE_STATUS_OFS);
    assign hit_gate   = (req.addr == `UIE_GATE_OFS);

    always_comb
    begin
        evt = 32'h0000_0000;
        // an event held high sets its flag again every cycle
        evt[`UIE_BIT_ISO]      = events.iso_done;
        evt[`UIE_BIT_ASYNC]    = events.async_done;
        evt[`UIE_BIT_PERIODIC] = events.periodic_done;
        evt[`UIE_BIT_CLOCK]    = events.clock_stable;
        evt[`UIE_BIT_SUSPEND]  = events.suspend_entry;
        evt[`UIE_BIT_DMA]      = events.dma_end;
        evt[`UIE_BIT_FRAME]    = events.frame_start;
    end

    always_comb
    begin
        gate_d = gate_q;
        flag_d = flag_q;
        // reserved enable bits are kept at zero whatever is written
        if (req.wr && hit_gate)
            gate_d = req.wdata & `UIE_SOURCE_MASK;
        // write one to clear; a new event in the same cycle wins
        if (req.wr && hit_status)
            flag_d = flag_q & ~req.wdata;
        flag_d = (flag_d | evt) & `UIE_SOURCE_MASK;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            gate_q <= `UIE_GATE_RESET;
            flag_q <= `UIE_STATUS_RESET;
        end
        else
        begin
            gate_q <= gate_d;
            flag_q <= flag_d;
        end
    end

    always_comb
    begin
        status_view = flag_q;
        if (settle_q == uie_pkg::UIE_SETTLED)
            status_view = flag_q | `UIE_SETTLE_MASK;
    end

    // ********************************************************
    // per-source view of gate and flag bits
    // ********************************************************
    // completion events arrive already qualified by the list masks
    logic       iso_list_done_enable;
    logic       async_list_done_enable;
    logic       periodic_list_done_enable;
    logic       clock_stable_enable;
    logic       suspend_entry_enable;
    logic       dma_transfer_end_enable;
    logic       frame_start_enable;

    logic       iso_list_done_flag;
    logic       async_list_done_flag;
    logic       periodic_list_done_flag;
    logic       clock_stable_flag;
    logic       suspend_entry_flag;
    logic       dma_transfer_end_flag;
    logic       frame_start_flag;
    logic [6:0] src_req;

    assign iso_list_done_enable      = gate_q[`UIE_BIT_ISO];
    assign async_list_done_enable    = gate_q[`UIE_BIT_ASYNC];
    assign periodic_list_done_enable = gate_q[`UIE_BIT_PERIODIC];
    assign clock_stable_enable       = gate_q[`UIE_BIT_CLOCK];
    assign suspend_entry_enable      = gate_q[`UIE_BIT_SUSPEND];
    assign dma_transfer_end_enable   = gate_q[`UIE_BIT_DMA];
    assign frame_start_enable        = gate_q[`UIE_BIT_FRAME];

    assign iso_list_done_flag        = flag_q[`UIE_BIT_ISO];
    assign async_list_done_flag      = flag_q[`UIE_BIT_ASYNC];
    assign periodic_list_done_flag   = flag_q[`UIE_BIT_PERIODIC];
    assign clock_stable_flag         = flag_q[`UIE_BIT_CLOCK];
    assign suspend_entry_flag        = flag_q[`UIE_BIT_SUSPEND];
    assign dma_transfer_end_flag     = flag_q[`UIE_BIT_DMA];
    assign frame_start_flag          = flag_q[`UIE_BIT_FRAME];

    // one and-gate per source, kept apart so each gate bit is traceable
    always_comb
    begin
        src_req    = 7'h00;
        src_req[6] = iso_list_done_flag
                   & iso_list_done_enable;
        src_req[5] = async_list_done_flag
                   & async_list_done_enable;
        src_req[4] = periodic_list_done_flag
                   & periodic_list_done_enable;
        src_req[3] = clock_stable_flag
                   & clock_stable_enable;
        src_req[2] = suspend_entry_flag
                   & suspend_entry_enable;
        src_req[1] = dma_transfer_end_flag
                   & dma_transfer_end_enable;
        src_req[0] = frame_start_flag
                   & frame_start_enable;
    end

    // ********************************************************
    // read port and irq line
    // ********************************************************
    logic [31:0] rdata_d;
    logic        irq_d;

    always_comb
    begin
        // unmapped or idle cycles return zero, never stale data
        rdata_d = 32'h0000_0000;
        if (req.rd && hit_status)
            rdata_d = status_view;
        else if (req.rd && hit_gate)
            rdata_d = gate_q;
        // flags stay set while gated off; enabling later raises irq
        irq_d = |src_req;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            rdata <= 32'h0000_0000;
            irq   <= 1'b0;
        end
        else
        begin
            rdata <= rdata_d;
            irq   <= irq_d;
        end
    end

endmodule
`default_nettype wire

// ---- verif/uie_irq_logic_properties.sv ----
// port checker of the usb host irq enable logic
`timescale 1ns/10ps
`default_nettype none
module uie_irq_chk #(parameter int SETTLE_CYCLES = 10) (
    input wire logic                 mclk,   // clock
    input wire logic                 rst_n,  // reset, low
    input wire uie_pkg::uie_req_t    req,    // bus request
    input wire uie_pkg::uie_events_t events, // event pulses
    input wire logic [31:0]          rdata,  // read data
    input wire logic                 irq     // irq line
);
    logic [31:0] gate_q;
    logic [6:0]  g;
    // gate bits lined up with the event struct, msb first
    assign g = {gate_q[9:5], gate_q[3], gate_q[1]};
    always_ff @(posedge mclk)
        if (!rst_n) gate_q <= 32'h0;
        else if (req.wr && req.addr == 16'h0314) gate_q <= req.wdata;
    logic [15:0] age_q;
    logic        settled_m;
    // cycles since reset, saturating, to split early and late reads
    always_ff @(posedge mclk)
        if (!rst_n) age_q <= 16'h0000;
        else if (age_q != 16'hFFFF) age_q <= age_q + 16'h0001;
    assign settled_m = (age_q >= 16'(SETTLE_CYCLES));
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    property p_none; g == 7'h0 |=> !irq; endproperty
    a_none: assert property (p_none) else $error("irq, no gate");
    property p_iso; events[6] && g[6] && !req.wr |=> ##1 irq; endproperty
    a_iso: assert property (p_iso) else $error("no iso irq");
    property p_asy; events[5] && g[5] && !req.wr |=> ##1 irq; endproperty
    a_asy: assert property (p_asy) else $error("no async irq");
    property p_per; events[4] && g[4] && !req.wr |=> ##1 irq; endproperty
    a_per: assert property (p_per) else $error("no periodic irq");
    property p_clk; events[3] && g[3] && !req.wr |=> ##1 irq; endproperty
    a_clk: assert property (p_clk) else $error("no clock irq");
    property p_sus; events[2] && g[2] && !req.wr |=> ##1 irq; endproperty
    a_sus: assert property (p_sus) else $error("no suspend irq");
    property p_dma; events[1] && g[1] && !req.wr |=> ##1 irq; endproperty
    a_dma: assert property (p_dma) else $error("no dma irq");
    property p_sof; events[0] && g[0] && !req.wr |=> ##1 irq; endproperty
    a_sof: assert property (p_sof) else $error("no frame irq");
    property p_grd;
        req.rd && req.addr == 16'h0314 |=> rdata == (gate_q & 32'h0000_03EA);
    endproperty
    a_grd: assert property (p_grd) else $error("gate readback");
    property p_early;
        req.rd && req.addr == 16'h0310 && !settled_m
            |=> !rdata[2] && !rdata[0];
    endproperty
    a_early: assert property (p_early) else $error("early settle");
    property p_late;
        req.rd && req.addr == 16'h0310 && settled_m
            |=> rdata[2] && rdata[0];
    endproperty
    a_late: assert property (p_late) else $error("late settle");
endmodule
bind uie_irq_logic uie_irq_chk #(.SETTLE_CYCLES(SETTLE_CYCLES)) chk_i
    (.mclk, .rst_n, .req, .events, .rdata, .irq);
`default_nettype wire

// ---- verif/uie_host_model.sv ----
// host processor model driving the register request bus
`timescale 1ns/10ps
`default_nettype none
module uie_host_model (
    input  wire logic              mclk,  // clock
    input  wire logic [31:0]       rdata, // read data
    output var uie_pkg::uie_req_t  req    // request
);
    initial req = '{1'b0, 1'b0, 16'h0, 32'h0};
    // released fields flip so a late sample reads garbage
    task automatic acc(input logic w, input logic [15:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(negedge mclk);
        req = '{w, !w, a, d};
        @(negedge mclk);
        q = rdata;
        req = '{1'b0, 1'b0, ~a, ~d};
    endtask
endmodule
`default_nettype wire

// ---- verif/usb_host_irq_enable_logic_tb_top.sv ----
// testbench of the usb host irq enable logic
`timescale 1ns/10ps
`default_nettype none
module usb_host_irq_enable_logic_tb_top;
    logic                 mclk, rst_n, irq;
    logic [31:0]          rdata, q;
    uie_pkg::uie_req_t    req;
    uie_pkg::uie_events_t events;
    int                   n_fail, checks_done;
    typedef struct packed {
        logic [6:0]  ev;    // event pulse pattern
        logic [31:0] gate;  // gate written first
        logic        irq;   // irq expected
        logic [31:0] stat;  // status expected
    } uie_row_t;
    uie_row_t             rows[14] = '{
        '{7'h40, 32'h0000_0200, 1'b1, 32'h0000_0205},
        '{7'h40, 32'h0000_01EA, 1'b0, 32'h0000_0205},
        '{7'h20, 32'h0000_0100, 1'b1, 32'h0000_0105},
        '{7'h20, 32'h0000_02EA, 1'b0, 32'h0000_0105},
        '{7'h10, 32'h0000_0080, 1'b1, 32'h0000_0085},
        '{7'h10, 32'h0000_036A, 1'b0, 32'h0000_0085},
        '{7'h08, 32'h0000_0040, 1'b1, 32'h0000_0045},
        '{7'h08, 32'h0000_03AA, 1'b0, 32'h0000_0045},
        '{7'h04, 32'h0000_0020, 1'b1, 32'h0000_0025},
        '{7'h04, 32'h0000_03CA, 1'b0, 32'h0000_0025},
        '{7'h02, 32'h0000_0008, 1'b1, 32'h0000_000D},
        '{7'h02, 32'h0000_03E2, 1'b0, 32'h0000_000D},
        '{7'h01, 32'h0000_0002, 1'b1, 32'h0000_0007},
        '{7'h01, 32'h0000_03E8, 1'b0, 32'h0000_0007}
    };
    uie_irq_logic #(.SETTLE_CYCLES(4)) uie_irq_logic_i
        (.mclk, .rst_n, .req, .events, .rdata, .irq);
    uie_host_model uie_host_model_i (.mclk, .rdata, .req);
    initial
    begin
        mclk = 0;
        forever #50 mclk = ~mclk;
    end
    task automatic chk(input string s, input logic [31:0] e, g);
        checks_done++;
        if (g !== e)
        begin
            n_fail++;
            $display("BAD %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] e);
        uie_host_model_i.acc(1'b0, a, 32'h0, q);
        chk("rdata", e, q);
    endtask
    task automatic w(input logic [15:0] a, input logic [31:0] d);
        uie_host_model_i.acc(1'b1, a, d, q);
    endtask
    task automatic report_and_stop;
        $display("checks %0d fails %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        rst_n = 0;
        events = '0;
        repeat (6) @(negedge mclk);
        rst_n = 1;
        chk("irq", 0, irq);
        rd(16'h0310, 32'h0);
        rd(16'h0314, 32'h0);
        repeat (4) @(negedge mclk);
        rd(16'h0310, 32'h5);
        foreach (rows[i])
        begin
            w(16'h0314, rows[i].gate);
            @(negedge mclk);
            events = rows[i].ev;
            @(negedge mclk);
            events = '0;
            @(negedge mclk);
            chk("irq", 32'(rows[i].irq), 32'(irq));
            rd(16'h0310, rows[i].stat);
            w(16'h0310, rows[i].stat & 32'h0000_03EA);
            @(negedge mclk);
            chk("irq", 0, irq);
        end
        // event and its clear in one cycle: the event must win
        fork
            w(16'h0310, 32'h0000_0002);
            begin
                @(negedge mclk);
                events = 7'h01;
                @(negedge mclk);
                events = '0;
            end
        join
        rd(16'h0310, 32'h0000_0007);
        w(16'h0310, 32'h0000_0002);
        rd(16'h0310, 32'h0000_0005);
        // reserved gate bits must not stick
        w(16'h0314, 32'hFFFF_FFFF);
        rd(16'h0314, 32'h3EA);
        rd(16'h0318, 32'h0);
        events = 7'h01;
        @(negedge mclk);
        events = '0;
        @(negedge mclk);
        chk("irq", 1, irq);
        w(16'h0314, 32'h0);
        @(negedge mclk);
        chk("irq", 0, irq);
        // reset in mid-run clears gate and flags and restarts settling
        w(16'h0314, 32'h0000_0002);
        rst_n = 0;
        repeat (2) @(negedge mclk);
        rst_n = 1;
        chk("irq", 0, irq);
        rd(16'h0310, 32'h0);
        rd(16'h0314, 32'h0);
        repeat (4) @(negedge mclk);
        rd(16'h0310, 32'h5);
        report_and_stop;
    end
    initial
    begin
        #100us;
        n_fail++;
        report_and_stop;
    end
endmodule
`default_nettype wire
